// >>> logic/port8_regs.vh
`ifndef PORT8_REGS_VH
`define PORT8_REGS_VH

// ==========================================================
// Register byte addresses
`define ADDR_EDGE_SEL_LO 16'hf024
`define ADDR_EDGE_SEL_HI 16'hf025
`define ADDR_EDGE_SAMPLE 16'hf026
`define ADDR_IRQ_STATUS 16'hf028
`define ADDR_IRQ_MASK 16'hf029
`define ADDR_FUNC_SEL_LO 16'hf244
`define ADDR_FUNC_SEL_HI 16'hf245

// ==========================================================
// Reset values
`define RST_BYTE 8'h00

// ==========================================================
// Pin function codes {hi, lo}
`define FN_GPIO 2'h0
`define FN_SECOND 2'h1
`define FN_THIRD 2'h2
`define FN_BAD 2'h3

// ==========================================================
// Edge modes {hi, lo}
`define EDGE_OFF 2'h0
`define EDGE_FALL 2'h1
`define EDGE_RISE 2'h2
`define EDGE_BOTH 2'h3

// ==========================================================
// Drive modes {ctrl hi, ctrl lo}
`define DRV_HIZ 2'h0
`define DRV_PCH 2'h1
`define DRV_NCH 2'h2
`define DRV_CMOS 2'h3

`endif

// >>> logic/port8_function_select_edge_irq.v
// Function
// RULE1 - Two function-select registers, reset zero, 16/8 access
// RULE2 - Per-pin code from high and low bits
// RULE3 - Pin0: I2C data or sync A input
// RULE4 - Pin1: I2C clock or sync A clock
// RULE5 - Pin2: async B receive or sync A output
// RULE6 - Pin3: async B or async A transmit
// RULE7 - Pin4: only sync B data input
// RULE8 - Pin5: only sync B clock
// RULE9 - Pin6: async A receive or sync B output
// RULE10 - Pin7: async A or async B transmit
// RULE11 - Bad code, Hi-Z/P-channel output: high impedance
// RULE12 - Bad code, N-channel/CMOS output: drive low
// RULE13 - Two edge-select registers, reset zero
// RULE14 - Edge code: off, fall, rise, both
// RULE15 - Sampling-select register, one bit per pin
// RULE16 - Selected edge raises that pin's request
// RULE17 - Sampling uses the 16 kHz tick
// RULE18 - No sampling while in stop mode
// RULE19 - Sampled edges compare consecutive tick samples
`timescale 1ns/1ns
`default_nettype none
`include "port8_regs.vh"

module port8_function_select_edge_irq (
  input wire clock,
  input wire rst,
  // Register port
  input wire [15:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire bus_word,
  output reg [15:0] bus_rdata,
  // Pins
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  // Port settings held elsewhere
  input wire [7:0] port_output_value,
  input wire [7:0] port_dir_input,
  input wire [7:0] port_ctrl_low,
  input wire [7:0] port_ctrl_high,
  // Timing
  input wire low_speed_sample_tick,
  input wire stop_mode,
  // I2C
  input wire i2c_sda_drive_low,
  input wire i2c_scl_drive_low,
  output reg i2c_sda_in,
  output reg i2c_scl_in,
  // Synchronous serial A
  output reg sync_a_data_in,
  input wire sync_a_data_out,
  input wire sync_a_clock_out,
  input wire sync_a_clock_oe,
  output reg sync_a_clock_in,
  // Synchronous serial B
  output reg sync_b_data_in,
  input wire sync_b_data_out,
  input wire sync_b_clock_out,
  input wire sync_b_clock_oe,
  output reg sync_b_clock_in,
  // UARTs
  output reg async_a_receive,
  input wire async_a_transmit,
  output reg async_b_receive,
  input wire async_b_transmit,
  // Interrupts
  output reg [7:0] pin_irq_req,
  output reg irq
);

  // ========================================================
  // Functions
  // ========================================================
  // Pad drive for a value under a drive mode: {oe, out}
  function [1:0] drive;
    input [1:0] mode;
    input val;
    begin
      case (mode)
        `DRV_PCH: drive = {val, 1'b1}; // Only pulls high
        `DRV_NCH: drive = {~val, 1'b0}; // Only pulls low
        `DRV_CMOS: drive = {1'b1, val};
        default: drive = 2'b00; // Hi-Z output
      endcase
    end
  endfunction

  // Code of pin n from a low/high register pair
  function [1:0] code_of;
    input [7:0] hi;
    input [7:0] lo;
    input [2:0] n;
    begin
      code_of = {hi[n], lo[n]};
    end
  endfunction

  // ========================================================
  // Registers
  // ========================================================
  reg [7:0] function_select_low; // Low code bits
  reg [7:0] function_select_high; // High code bits
  reg [7:0] edge_select_low; // Edge code low bits
  reg [7:0] edge_select_high; // Edge code high bits
  reg [7:0] edge_sampling_select; // Per-pin sampling
  reg [7:0] irq_status_r; // Sticky edge events
  reg [7:0] irq_mask_r; // Enables onto irq

  // Decoded write strobes
  wire wr_fsl;
  wire wr_fsh;
  wire byte_op;
  assign byte_op = ~bus_word;
  // Word access only at the low select address
  assign wr_fsl = bus_wr & (bus_addr == `ADDR_FUNC_SEL_LO);
  assign wr_fsh = bus_wr & ((byte_op & (bus_addr == `ADDR_FUNC_SEL_HI)) |
                  (bus_word & (bus_addr == `ADDR_FUNC_SEL_LO)));

  // Byte writes to the remaining registers
  wire wr_byte;
  assign wr_byte = bus_wr & byte_op;

  // Edge events found this cycle
  reg [7:0] edge_evt;

  // Status next value, set beats clear
  wire [7:0] status_clr;
  wire [7:0] irq_status_nxt;
  assign status_clr = (wr_byte & (bus_addr == `ADDR_IRQ_STATUS)) ?
                      bus_wdata[7:0] : 8'h00;
  assign irq_status_nxt = (irq_status_r & ~status_clr) | edge_evt; // RULE16

  // Register writes
  always @(posedge clock) begin
    if (rst) begin
      function_select_low <= `RST_BYTE; // RULE1
      function_select_high <= `RST_BYTE; // RULE1
      edge_select_low <= `RST_BYTE; // RULE13
      edge_select_high <= `RST_BYTE; // RULE13
      edge_sampling_select <= `RST_BYTE; // RULE15
      irq_status_r <= 8'h00;
      irq_mask_r <= 8'h00;
    end else begin
      // Low select: byte or low half of word
      if (wr_fsl) begin
        function_select_low <= bus_wdata[7:0]; // RULE1
      end
      // High select: byte, or high half of word
      if (wr_fsh) begin
        if (bus_word) begin
          function_select_high <= bus_wdata[15:8]; // RULE1
        end else begin
          function_select_high <= bus_wdata[7:0]; // RULE1
        end
      end
      // Byte-only registers; word writes are dropped
      if (wr_byte && bus_addr == `ADDR_EDGE_SEL_LO) begin
        edge_select_low <= bus_wdata[7:0]; // RULE13
      end
      if (wr_byte && bus_addr == `ADDR_EDGE_SEL_HI) begin
        edge_select_high <= bus_wdata[7:0]; // RULE13
      end
      if (wr_byte && bus_addr == `ADDR_EDGE_SAMPLE) begin
        edge_sampling_select <= bus_wdata[7:0]; // RULE15
      end
      if (wr_byte && bus_addr == `ADDR_IRQ_MASK) begin
        irq_mask_r <= bus_wdata[7:0];
      end
      irq_status_r <= irq_status_nxt;
    end
  end

  // ========================================================
  // Read port
  // ========================================================
  reg [15:0] rdata_nxt;

  // Address decode; unmapped or illegal word reads give zero
  always @* begin
    rdata_nxt = 16'h0000;
    if (!bus_rd) begin
      rdata_nxt = 16'h0000;
    end else if (bus_addr == `ADDR_FUNC_SEL_LO) begin
      if (bus_word) begin
        rdata_nxt = {function_select_high, function_select_low};
      end else begin
        rdata_nxt = {8'h00, function_select_low};
      end
    end else if (bus_word) begin
      rdata_nxt = 16'h0000; // 16-bit only allowed at one address
    end else if (bus_addr == `ADDR_FUNC_SEL_HI) begin
      rdata_nxt = {8'h00, function_select_high};
    end else if (bus_addr == `ADDR_EDGE_SEL_LO) begin
      rdata_nxt = {8'h00, edge_select_low};
    end else if (bus_addr == `ADDR_EDGE_SEL_HI) begin
      rdata_nxt = {8'h00, edge_select_high};
    end else if (bus_addr == `ADDR_EDGE_SAMPLE) begin
      rdata_nxt = {8'h00, edge_sampling_select};
    end else if (bus_addr == `ADDR_IRQ_STATUS) begin
      rdata_nxt = {8'h00, irq_status_r};
    end else if (bus_addr == `ADDR_IRQ_MASK) begin
      rdata_nxt = {8'h00, irq_mask_r};
    end
  end

  // Data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= rdata_nxt;
    end
  end

  // ========================================================
  // Pin input synchroniser
  // ========================================================
  reg [7:0] pin_meta_r; // First stage, read only by second
  reg [7:0] pin_sync_r; // Safe pin level
  reg [7:0] pin_prev_r; // Level one clock earlier
  reg [7:0] pin_smp_r; // Level at the last tick

  // Sampling is live for a pin only while the tick runs
  wire [7:0] smp_on;
  assign smp_on = stop_mode ? 8'h00 : edge_sampling_select; // RULE18

  // Per pin: sample at a tick, or track while unsampled
  wire [7:0] smp_take;
  assign smp_take = {8{low_speed_sample_tick}} | ~smp_on;

  // Two flops, then history for edge detection
  always @(posedge clock) begin
    if (rst) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
      pin_prev_r <= 8'h00;
      pin_smp_r <= 8'h00;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      // Unsampled pins keep the sample current, so turning
      // sampling on later cannot fake an edge
      pin_smp_r <= (smp_take & pin_sync_r) | (~smp_take & pin_smp_r); // RULE17
    end
  end

  // ========================================================
  // Edge detection
  // ========================================================
  reg [7:0] rise;
  reg [7:0] fall;
  reg [1:0] ecode;
  integer i;

  // Compare against last clock or last tick sample
  always @* begin
    rise = 8'h00;
    fall = 8'h00;
    edge_evt = 8'h00;
    ecode = `EDGE_OFF;
    for (i = 0; i < 8; i = i + 1) begin
      if (smp_on[i]) begin
        // Sampled: only at a tick, consecutive samples differ
        rise[i] = low_speed_sample_tick & pin_sync_r[i] &
                  ~pin_smp_r[i]; // RULE19
        fall[i] = low_speed_sample_tick & ~pin_sync_r[i] &
                  pin_smp_r[i]; // RULE19
      end else begin
        // Unsampled: every system clock
        rise[i] = pin_sync_r[i] & ~pin_prev_r[i]; // RULE19
        fall[i] = ~pin_sync_r[i] & pin_prev_r[i]; // RULE19
      end
      ecode = code_of(edge_select_high, edge_select_low, i[2:0]);
      case (ecode) // RULE14
        `EDGE_FALL: edge_evt[i] = fall[i];
        `EDGE_RISE: edge_evt[i] = rise[i];
        `EDGE_BOTH: edge_evt[i] = rise[i] | fall[i];
        default: edge_evt[i] = 1'b0; // Disabled
      endcase
    end
  end

  // Request pulses and the combined level interrupt
  always @(posedge clock) begin
    if (rst) begin
      pin_irq_req <= 8'h00;
      irq <= 1'b0;
    end else begin
      pin_irq_req <= edge_evt; // RULE16
      irq <= |(irq_status_nxt & irq_mask_r);
    end
  end

  // ========================================================
  // Function routing to the pads
  // ========================================================
  reg [1:0] fc [0:7]; // Function code per pin
  reg [1:0] dmode; // Drive mode of the pin in hand
  reg [1:0] pad; // {oe, out} for the pin in hand
  reg [7:0] pin_out_nxt;
  reg [7:0] pin_oe_nxt;
  integer k;

  // Per-pin source select
  always @* begin
    pin_out_nxt = 8'h00;
    pin_oe_nxt = 8'h00;
    pad = 2'b00;
    dmode = `DRV_HIZ;
    for (k = 0; k < 8; k = k + 1) begin
      fc[k] = code_of(function_select_high, function_select_low,
                      k[2:0]); // RULE2
    end
    for (k = 0; k < 8; k = k + 1) begin
      dmode = {port_ctrl_high[k], port_ctrl_low[k]};
      // General-purpose default
      pad = drive(dmode, port_output_value[k]); // RULE2
      case (k)
        0: begin
          if (fc[0] == `FN_SECOND) begin
            pad = {i2c_sda_drive_low, 1'b0}; // RULE3
          end else if (fc[0] == `FN_THIRD) begin
            pad = 2'b00; // Input only // RULE3
          end
        end
        1: begin
          if (fc[1] == `FN_SECOND) begin
            pad = {i2c_scl_drive_low, 1'b0}; // RULE4
          end else if (fc[1] == `FN_THIRD) begin
            pad = {sync_a_clock_oe, sync_a_clock_out}; // RULE4
          end
        end
        2: begin
          if (fc[2] == `FN_SECOND) begin
            pad = 2'b00; // RULE5
          end else if (fc[2] == `FN_THIRD) begin
            pad = drive(dmode, sync_a_data_out); // RULE5
          end
        end
        3: begin
          if (fc[3] == `FN_SECOND) begin
            pad = drive(dmode, async_b_transmit); // RULE6
          end else if (fc[3] == `FN_THIRD) begin
            pad = drive(dmode, async_a_transmit); // RULE6
          end
        end
        4: begin
          if (fc[4] == `FN_THIRD) begin
            pad = 2'b00; // RULE7
          end
        end
        5: begin
          if (fc[5] == `FN_THIRD) begin
            pad = {sync_b_clock_oe, sync_b_clock_out}; // RULE8
          end
        end
        6: begin
          if (fc[6] == `FN_SECOND) begin
            pad = 2'b00; // RULE9
          end else if (fc[6] == `FN_THIRD) begin
            pad = drive(dmode, sync_b_data_out); // RULE9
          end
        end
        default: begin
          if (fc[7] == `FN_SECOND) begin
            pad = drive(dmode, async_a_transmit); // RULE10
          end else if (fc[7] == `FN_THIRD) begin
            pad = drive(dmode, async_b_transmit); // RULE10
          end
        end
      endcase
      // Prohibited codes: pins 4,5 reject 01 as well
      if (fc[k] == `FN_BAD ||
          ((k == 4 || k == 5) && fc[k] == `FN_SECOND)) begin // RULE7
        // A forced low; P-channel cannot pull low so stays off
        pad = drive(dmode, 1'b0); // RULE11 RULE12
      end
      // Input direction never drives, except peripheral-owned pads
      if (port_dir_input[k] && (fc[k] == `FN_GPIO || fc[k] == `FN_BAD ||
          ((k == 4 || k == 5) && fc[k] == `FN_SECOND))) begin
        pad = 2'b00;
      end
      pin_oe_nxt[k] = pad[1];
      pin_out_nxt[k] = pad[1] & pad[0];
    end
  end

  // Pads and peripheral inputs leave from flops
  always @(posedge clock) begin
    if (rst) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      i2c_sda_in <= 1'b1;
      i2c_scl_in <= 1'b1;
      sync_a_data_in <= 1'b1;
      sync_a_clock_in <= 1'b1;
      sync_b_data_in <= 1'b1;
      sync_b_clock_in <= 1'b1;
      async_a_receive <= 1'b1;
      async_b_receive <= 1'b1;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe <= pin_oe_nxt;
      // Unselected peripheral inputs idle high
      i2c_sda_in <= (fc[0] == `FN_SECOND) ? pin_sync_r[0] : 1'b1; // RULE3
      i2c_scl_in <= (fc[1] == `FN_SECOND) ? pin_sync_r[1] : 1'b1; // RULE4
      sync_a_data_in <= (fc[0] == `FN_THIRD) ? pin_sync_r[0] : 1'b1; // RULE3
      sync_a_clock_in <= (fc[1] == `FN_THIRD) ? pin_sync_r[1] : 1'b1; // RULE4
      async_b_receive <= (fc[2] == `FN_SECOND) ? pin_sync_r[2] : 1'b1; // RULE5
      sync_b_data_in <= (fc[4] == `FN_THIRD) ? pin_sync_r[4] : 1'b1; // RULE7
      sync_b_clock_in <= (fc[5] == `FN_THIRD) ? pin_sync_r[5] : 1'b1; // RULE8
      async_a_receive <= (fc[6] == `FN_SECOND) ? pin_sync_r[6] : 1'b1; // RULE9
    end
  end

endmodule // port8_function_select_edge_irq
`default_nettype wire

// >>> tb/port8_far_side.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Far side: pads, peripherals, tick
// ==========================================================
module port8_far_side #(
  parameter int TICK_DIV = 625 // 10 MHz over 16 kHz
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic stop_mode,
  input wire logic lvl, // Level of every peripheral output
  input wire logic [7:0] pad_level, // Level seen on the pads
  output logic [7:0] pin_in,
  output var logic tick,
  output logic periph_out,
  output logic periph_oe,
  output logic i2c_low
);
  int cnt; // Tick divider
  assign pin_in = pad_level;
  assign periph_out = lvl;
  // Serial masters own their clocks
  assign periph_oe = 1'b1;
  // I2C pulls low when the data level is low
  assign i2c_low = ~lvl;
  // 16 kHz tick, held off with the divider cleared to zero in stop
  always @(posedge clock) begin
    if (rst || stop_mode) begin
      cnt <= 0;
      tick <= 1'b0;
    end else begin
      cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      tick <= (cnt == TICK_DIV - 1);
    end
  end
endmodule // port8_far_side
`default_nettype wire

// >>> tb/port8_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "port8_regs.vh"
module port8_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_word,
  input wire logic [15:0] bus_rdata,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] port_dir_input,
  input wire logic [7:0] port_ctrl_low,
  input wire logic [7:0] port_ctrl_high,
  input wire logic i2c_sda_drive_low,
  input wire logic async_a_transmit,
  input wire logic async_a_receive,
  input wire logic [7:0] pin_irq_req,
  input wire logic irq
);
  // ==========================================================
  // Shadow of the function selects
  logic [7:0] fs_lo_r; // Low code bits
  logic [7:0] fs_hi_r; // High code bits
  wire lo_hit = bus_wr && bus_addr == `ADDR_FUNC_SEL_LO;
  wire hi_hit = bus_wr && !bus_word && bus_addr == `ADDR_FUNC_SEL_HI;
  wire [1:0] code3 = {fs_hi_r[3], fs_lo_r[3]};
  wire [1:0] code6 = {fs_hi_r[6], fs_lo_r[6]};
  wire out3 = !port_dir_input[3]; // Pin 3 in output mode
  // Word writes: high byte in [15:8]
  always @(posedge clock) begin
    if (rst) begin
      fs_lo_r <= 8'h00;
      fs_hi_r <= 8'h00;
    end else begin
      if (lo_hit)
        fs_lo_r <= bus_wdata[7:0];
      if (lo_hit && bus_word)
        fs_hi_r <= bus_wdata[15:8];
      else if (hi_hit)
        fs_hi_r <= bus_wdata[7:0];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_rdata_idle;
    bus_rdata != 16'h0000 |-> $past(bus_rd);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
  property p_word_read;
    bus_rd && bus_word && bus_addr == `ADDR_FUNC_SEL_LO |=> bus_rdata == {fs_hi_r, fs_lo_r};
  endproperty
  a_word_read: assert property (p_word_read) else $error("word read wrong");
  property p_irq_cause;
    $rose(irq) |-> pin_irq_req != 8'h00 || $past(bus_wr && bus_addr == `ADDR_IRQ_MASK)
      || $past(bus_wr && bus_addr == `ADDR_IRQ_MASK, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_no_stray_out;
    (pin_out & ~pin_oe) == 8'h00;
  endproperty
  a_no_stray_out: assert property (p_no_stray_out) else $error("undriven pad high");
  property p_pin0_i2c;
    {fs_hi_r[0], fs_lo_r[0]} == 2'h1 |=> pin_oe[0] == $past(i2c_sda_drive_low) && !pin_out[0];
  endproperty
  a_pin0_i2c: assert property (p_pin0_i2c) else $error("pin 0 data line wrong");
  property p_pin3_tx;
    code3 == 2'h2 && out3 && port_ctrl_high[3] && port_ctrl_low[3]
      |=> pin_oe[3] && pin_out[3] == $past(async_a_transmit);
  endproperty
  a_pin3_tx: assert property (p_pin3_tx) else $error("pin 3 transmit wrong");
  property p_bad_low;
    code3 == 2'h3 && out3 && port_ctrl_high[3] |=> pin_oe[3] && !pin_out[3];
  endproperty
  a_bad_low: assert property (p_bad_low) else $error("pin 3 not low");
  property p_bad_hiz;
    code3 == 2'h3 && out3 && !port_ctrl_high[3] |=> !pin_oe[3];
  endproperty
  a_bad_hiz: assert property (p_bad_hiz) else $error("pin 3 not floating");
  property p_rx_idle;
    (code6 != 2'h1) [*2] |-> async_a_receive;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("receive not idle");
endmodule // port8_checker
bind port8_function_select_edge_irq port8_checker chk_i (.clock(clock), .rst(rst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_word(bus_word), .bus_rdata(bus_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .port_dir_input(port_dir_input), .port_ctrl_low(port_ctrl_low),
  .port_ctrl_high(port_ctrl_high), .i2c_sda_drive_low(i2c_sda_drive_low),
  .async_a_transmit(async_a_transmit), .async_a_receive(async_a_receive),
  .pin_irq_req(pin_irq_req), .irq(irq));
`default_nettype wire

// >>> tb/tb_port8_function_select_edge_irq.sv
`timescale 1ns/1ns
`default_nettype none
`include "port8_regs.vh"
module tb_port8_function_select_edge_irq;
  // ==========================================================
  // Signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic bus_word = 1'b0;
  logic [7:0] pov = 8'hff; // Port data, all high
  logic [7:0] dir_in = 8'h00;
  logic [7:0] ctrl_lo = 8'hff;
  logic [7:0] ctrl_hi = 8'hff;
  logic stop_mode = 1'b0;
  logic lvl = 1'b0;
  logic [7:0] pad_level = 8'h00;
  wire [15:0] bus_rdata;
  wire [7:0] pin_in, pin_out, pin_oe, pin_irq_req;
  wire tick, periph_out, periph_oe, i2c_low, irq;
  wire sda_i, scl_i, sa_d, sa_c, sb_d, sb_c, a_rx, b_rx;
  // Routed inputs
  wire [7:0] ins = {sda_i, scl_i, sa_d, sa_c, sb_d, sb_c, a_rx, b_rx};
  int n_fail = 0;
  int total_checks = 0;
  int n_req = 0; // Pin 0 request pulses
  int cycles = 0;
  initial forever #50 clock = ~clock;
  port8_far_side far (.clock(clock), .rst(rst), .stop_mode(stop_mode), .lvl(lvl),
    .pad_level(pad_level), .pin_in(pin_in), .tick(tick), .periph_out(periph_out),
    .periph_oe(periph_oe), .i2c_low(i2c_low));
  port8_function_select_edge_irq uut (.clock(clock), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_word(bus_word),
    .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_output_value(pov), .port_dir_input(dir_in), .port_ctrl_low(ctrl_lo),
    .port_ctrl_high(ctrl_hi), .low_speed_sample_tick(tick), .stop_mode(stop_mode),
    .i2c_sda_drive_low(i2c_low), .i2c_scl_drive_low(i2c_low), .i2c_sda_in(sda_i),
    .i2c_scl_in(scl_i), .sync_a_data_in(sa_d), .sync_a_data_out(periph_out),
    .sync_a_clock_out(periph_out), .sync_a_clock_oe(periph_oe), .sync_a_clock_in(sa_c),
    .sync_b_data_in(sb_d), .sync_b_data_out(periph_out), .sync_b_clock_out(periph_out),
    .sync_b_clock_oe(periph_oe), .sync_b_clock_in(sb_c), .async_a_receive(a_rx),
    .async_a_transmit(periph_out), .async_b_receive(b_rx),
    .async_b_transmit(periph_out), .pin_irq_req(pin_irq_req), .irq(irq));
  // Pulse count and hang guard
  always @(posedge clock) begin
    cycles++;
    if (pin_irq_req[0] === 1'b1)
      n_req++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end
  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_word <= w;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  // Read, data checked next cycle
  task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e);
    @(posedge clock);
    bus_addr <= a;
    bus_word <= w;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, e);
  endtask
  // Bounded wait for a tick
  task automatic wait_tick;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (tick !== 1'b1 && k < 700);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    logic [15:0] a [8] = '{`ADDR_EDGE_SEL_LO, `ADDR_EDGE_SEL_HI, `ADDR_EDGE_SAMPLE,
      `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_FUNC_SEL_LO, `ADDR_FUNC_SEL_HI, 16'hf030};
    foreach (a[i]) rd(a[i], 1'b0, 16'h0000);
    rd(`ADDR_FUNC_SEL_LO, 1'b1, 16'h0000);
  endtask
  task automatic t_register_rw;
    logic [15:0] a [5] = '{`ADDR_EDGE_SEL_LO, `ADDR_EDGE_SEL_HI, `ADDR_EDGE_SAMPLE,
      `ADDR_FUNC_SEL_LO, `ADDR_FUNC_SEL_HI};
    foreach (a[i]) begin
      wr(a[i], 16'h005a + 16'(i), 1'b0);
      rd(a[i], 1'b0, 16'h005a + 16'(i));
    end
    wr(`ADDR_FUNC_SEL_LO, 16'hc33c, 1'b1);
    rd(`ADDR_FUNC_SEL_LO, 1'b1, 16'hc33c);
    rd(`ADDR_FUNC_SEL_HI, 1'b0, 16'h00c3);
    // Word write to byte-only dropped
    wr(`ADDR_EDGE_SEL_LO, 16'h1111, 1'b1);
    rd(`ADDR_EDGE_SEL_LO, 1'b0, 16'h005a);
    foreach (a[i]) wr(a[i], 16'h0000, 1'b0);
  endtask
  // All pins, codes and levels
  task automatic t_functions;
    int kind1 [8] = '{3, 3, 2, 1, 4, 4, 2, 1};
    int kind2 [8] = '{2, 1, 1, 1, 2, 1, 1, 1};
    int in1 [8] = '{7, 6, 0, -1, -1, -1, 1, -1};
    int in2 [8] = '{5, 4, -1, -1, 3, 2, -1, -1};
    int k;
    int idx;
    logic [1:0] e;
    logic [7:0] ei;
    for (int n = 0; n < 8; n++)
      for (int c = 0; c < 4; c++)
        for (int l = 0; l < 2; l++) begin
          @(posedge clock);
          lvl <= l[0];
          wr(`ADDR_FUNC_SEL_LO, 16'((c & 1) << n), 1'b0);
          wr(`ADDR_FUNC_SEL_HI, 16'((c >> 1) << n), 1'b0);
          k = (c == 0) ? 0 : (c == 3) ? 4 : (c == 1) ? kind1[n] : kind2[n];
          idx = (c == 1) ? in1[n] : (c == 2) ? in2[n] : -1;
          // Kinds: port, driven output, input only, I2C, prohibited
          case (k)
            0: e = 2'b11;
            1: e = {1'b1, l[0]};
            2: e = 2'b00;
            3: e = {~l[0], 1'b0};
            default: e = 2'b10;
          endcase
          ei = 8'hff;
          if (idx >= 0)
            ei[idx] = 1'b0;
          cyc(1);
          #1 chk(16'({pin_oe[n], pin_out[n]}), 16'(e));
          chk(16'(ins), 16'(ei));
        end
  endtask
  // Pin 3 prohibited, each drive mode
  task automatic t_drive_modes;
    wr(`ADDR_FUNC_SEL_LO, 16'h0808, 1'b1);
    for (int d = 0; d < 5; d++) begin
      @(posedge clock);
      ctrl_hi <= {8{d[1]}};
      ctrl_lo <= {8{d[0]}};
      dir_in <= {8{d == 4}};
      cyc(2);
      #1 chk(16'({pin_oe[3], pin_out[3]}), 16'({d == 2 || d == 3, 1'b0}));
    end
    wr(`ADDR_FUNC_SEL_LO, 16'h0000, 1'b1);
  endtask
  // Edge modes, back-to-back changes
  task automatic t_edges;
    int base;
    wr(`ADDR_IRQ_MASK, 16'h0001, 1'b0);
    for (int m = 0; m < 4; m++) begin
      wr(`ADDR_EDGE_SEL_LO, 16'(m & 1), 1'b0);
      wr(`ADDR_EDGE_SEL_HI, 16'(m >> 1), 1'b0);
      base = n_req;
      for (int s = 0; s < 4; s++) begin
        @(posedge clock);
        pad_level[0] <= ~pad_level[0];
        if (s >= 2)
          cyc(6);
      end
      #1 chk(16'(n_req - base), 16'(2 * (m & 1) + 2 * (m >> 1)));
      chk(16'(irq), 16'(m != 0));
      rd(`ADDR_IRQ_STATUS, 1'b0, 16'(m != 0));
      wr(`ADDR_IRQ_STATUS, 16'h0001, 1'b0);
      #1 chk(16'(irq), 16'h0000);
    end
    // Masked event stays pending
    wr(`ADDR_IRQ_MASK, 16'h0000, 1'b0);
    @(posedge clock);
    pad_level[0] <= 1'b1;
    cyc(6);
    #1 chk(16'(irq), 16'h0000);
    wr(`ADDR_IRQ_MASK, 16'h0001, 1'b0);
    cyc(1);
    #1 chk(16'(irq), 16'h0001);
    wr(`ADDR_IRQ_STATUS, 16'h00ff, 1'b0);
  endtask
  // Sampled waits a tick; stop bypasses
  task automatic t_sampling;
    int base;
    wr(`ADDR_EDGE_SAMPLE, 16'h0001, 1'b0);
    base = n_req;
    wait_tick();
    pad_level[0] <= 1'b0;
    cyc(20);
    #1 chk(16'(n_req - base), 16'h0000);
    wait_tick();
    cyc(3);
    #1 chk(16'(n_req - base), 16'h0001);
    @(posedge clock);
    stop_mode <= 1'b1;
    pad_level[0] <= 1'b1;
    cyc(6);
    #1 chk(16'(n_req - base), 16'h0002);
    @(posedge clock);
    stop_mode <= 1'b0;
  endtask
  // ==========================================================
  // Verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset_values();
    t_register_rw();
    t_functions();
    t_drive_modes();
    t_edges();
    t_sampling();
    conclude();
  end
endmodule // tb_port8_function_select_edge_irq
`default_nettype wire
